// ---- core/sfrs_core.v ----
// command engine of the serial flash: array reads and status read/write
//
// What this block does
// - read 03h takes 24-bit address; first data bit on last address bit fall.
// - read 0Bh takes address plus 8 dummy bits, output on last dummy fall.
// - continued clocking increments address and streams following bytes.
// - address wraps from 3FFFFh to 00000h without a break.
// - select high ends a read; output stays high impedance while deselected.
// - status byte: busy, write latch, two protect bits, reserved, lock.
// - status read 05h is answered at any time, even while busy.
// - status shifts out msb first from the fall of the eighth opcode bit.
// - clocking past bit 0 repeats the current status byte from bit 7.
// - status write 01h plus data byte starts on select rising edge.
// - only protect bits and lock bit change on a status write.
// - status write runs internally; busy reads 1 until it completes.
// - protect and lock bits reset to zero; each commit goes out on nv_data with an nv_write pulse.
// - opcode, address and data sampled on rising clock, msb first.
// - non-read commands only act if select rises exactly after last bit.
// - write latch clears at power-on, on write disable 04h and on write completion.
// - lock set and protect pin low makes status write ignored.
`timescale 1ns/1ps
`default_nettype none
`include "sfrs_defs.vh"
module sfrs_core #(
  parameter CLK_MHZ = 25,
  parameter STWR_CYCLES = `SFRS_STWR_TIME_US * CLK_MHZ,
  parameter AW = 18
) (
  input wire ref_clk,
  input wire rst,
  input wire sck,
  input wire cs_n,
  input wire si,
  input wire wp_n,
  output reg so_o,
  output reg so_oe,
  output wire [7:0] mem_addr,
  output wire [AW-1:0] mem_addr_full,
  input wire [7:0] mem_data,
  output wire [2:0] nv_data,
  output reg nv_write
);
  localparam S_CMD = 2'h0;
  localparam S_ADDR = 2'h1;
  localparam S_DUMMY = 2'h2;
  localparam S_OUT = 2'h3;

  ////////////////////////////////////////////////////////////////
  // two-flop synchronisers for all pins; only stage two is read
  reg [3:0] sync1_r;
  reg [3:0] sync2_r;
  reg sck_d_r;
  always @(posedge ref_clk) begin
    sync1_r <= {wp_n, si, cs_n, sck};
    sync2_r <= sync1_r;
    sck_d_r <= sync2_r[0];
  end
  wire sck_s = sync2_r[0];
  wire cs_s = sync2_r[1];
  wire si_s = sync2_r[2];
  wire wp_s = sync2_r[3];
  wire sck_rise = sck_s & ~sck_d_r;
  wire sck_fall = ~sck_s & sck_d_r;

  ////////////////////////////////////////////////////////////////
  // state
  reg [1:0] state_r;
  reg [7:0] sh_r;
  reg [4:0] bitcnt_r;
  reg [7:0] opcode_r;
  reg [AW-1:0] addr_r;
  reg [7:0] out_r;
  reg [2:0] obit_r;
  reg [7:0] wdata_r;
  reg frame_done_r;
  reg frame_extra_r;
  reg cs_d_r;
  reg wel_r;
  reg busy_r;
  reg [2:0] nv_r;
  reg [2:0] nv_pend_r;
  reg [31:0] busy_cnt_r;

  // status byte as seen by the host; reserved bits read zero
  wire [7:0] status = {nv_r[2], 3'h0, nv_r[1:0], wel_r, busy_r};
  wire is_read = (opcode_r == `SFRS_OP_READ) || (opcode_r == `SFRS_OP_READ_FAST);
  wire [7:0] sh_in = {sh_r[6:0], si_s};
  wire cs_rise = cs_s & ~cs_d_r;

  assign mem_addr = addr_r[7:0];
  assign mem_addr_full = addr_r;
  assign nv_data = nv_r;

  ////////////////////////////////////////////////////////////////
  // serial command engine, rising edge shifts in, falling edge shifts out
  always @(posedge ref_clk) begin
    cs_d_r <= cs_s;
    if (rst || cs_s) begin
      state_r <= S_CMD;
      bitcnt_r <= 5'h00;
      so_oe <= 1'b0;
      so_o <= 1'b0;
      obit_r <= 3'h7;
      if (rst) begin
        opcode_r <= 8'h00;
        frame_done_r <= 1'b0;
        frame_extra_r <= 1'b0;
        addr_r <= {AW{1'b0}};
        sh_r <= 8'h00;
        wdata_r <= 8'h00;
        out_r <= 8'h00;
      end
    end else begin
      if (cs_d_r) begin
        frame_done_r <= 1'b0;
        frame_extra_r <= 1'b0;
        opcode_r <= 8'h00;
      end
      if (sck_rise) begin
        sh_r <= sh_in;
        bitcnt_r <= (bitcnt_r == 5'h17) ? 5'h00 : bitcnt_r + 5'h01;
        case (state_r)
          S_CMD: begin
            if (bitcnt_r == 5'h07) begin
              opcode_r <= sh_in;
              bitcnt_r <= 5'h00;
              if (sh_in == `SFRS_OP_READ || sh_in == `SFRS_OP_READ_FAST) begin
                state_r <= S_ADDR;
              end else if (sh_in == `SFRS_OP_STAT_RD) begin
                state_r <= S_OUT;
                out_r <= status;
              end else if (sh_in == `SFRS_OP_STAT_WR) begin
                state_r <= S_DUMMY;
              end else begin
                state_r <= S_DUMMY;
                frame_done_r <= 1'b1;
              end
            end
          end
          S_ADDR: begin
            addr_r <= {addr_r[AW-2:0], si_s};
            if (bitcnt_r == 5'h17) begin
              if (opcode_r == `SFRS_OP_READ) begin
                state_r <= S_OUT;
              end else begin
                state_r <= S_DUMMY;
              end
            end
          end
          S_DUMMY: begin
            // dummy bits of 0Bh, data byte of 01h, or overrun of short commands
            if (is_read) begin
              if (bitcnt_r == 5'h07) begin
                state_r <= S_OUT;
                bitcnt_r <= 5'h00;
              end
            end else if (frame_done_r) begin
              frame_extra_r <= 1'b1;
            end else if (bitcnt_r == 5'h07) begin
              wdata_r <= sh_in;
              frame_done_r <= 1'b1;
            end
          end
          default: begin
            if (!is_read) begin
              frame_extra_r <= 1'b1;
            end
          end
        endcase
      end
      if (sck_fall && state_r == S_OUT) begin
        so_oe <= 1'b1;
        obit_r <= obit_r - 3'h1;
        if (is_read) begin
          so_o <= (obit_r == 3'h7) ? mem_data[7] : out_r[obit_r];
          if (obit_r == 3'h7) begin
            out_r <= mem_data;
          end
          if (obit_r == 3'h0) begin
            // next byte address; the top wraps to zero
            addr_r <= (addr_r == `SFRS_ADDR_TOP) ? {AW{1'b0}} : addr_r + 1'b1;
          end
        end else begin
          // status is re-sampled at each bit 7 so polling sees fresh busy
          so_o <= (obit_r == 3'h7) ? status[7] : out_r[obit_r];
          if (obit_r == 3'h7) begin
            out_r <= status;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // write latch, busy timer and nonvolatile protect bits
  wire frame_ok = cs_rise && frame_done_r && !frame_extra_r;
  wire locked = nv_r[2] && !wp_s;
  always @(posedge ref_clk) begin
    if (rst) begin
      wel_r <= 1'b0;
      busy_r <= 1'b0;
      busy_cnt_r <= 32'h00000000;
      nv_r <= `SFRS_NV_RESET;
      nv_pend_r <= 3'h0;
      nv_write <= 1'b0;
    end else begin
      nv_write <= 1'b0;
      if (busy_r) begin
        if (busy_cnt_r == 32'h00000000) begin
          busy_r <= 1'b0;
          wel_r <= 1'b0;
          nv_r <= nv_pend_r;
          nv_write <= 1'b1;
        end else begin
          busy_cnt_r <= busy_cnt_r - 32'h00000001;
        end
      end else if (frame_ok) begin
        if (opcode_r == `SFRS_OP_WR_EN) begin
          wel_r <= 1'b1;
        end else if (opcode_r == `SFRS_OP_WR_DIS) begin
          wel_r <= 1'b0;
        end else if (opcode_r == `SFRS_OP_STAT_WR && wel_r && !locked) begin
          busy_r <= 1'b1;
          busy_cnt_r <= STWR_CYCLES - 1;
          // bits 0, 1 and 4-6 of the data byte are dropped
          nv_pend_r <= {wdata_r[`SFRS_ST_LOCK], wdata_r[`SFRS_ST_BP_HI],
            wdata_r[`SFRS_ST_BP_LO]};
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- core/sfrs_defs.vh ----
// constants for the serial flash read and status command block
`ifndef SFRS_DEFS_VH
`define SFRS_DEFS_VH
`define SFRS_OP_READ 8'h03
`define SFRS_OP_READ_FAST 8'h0B
`define SFRS_OP_STAT_RD 8'h05
`define SFRS_OP_STAT_WR 8'h01
`define SFRS_OP_WR_EN 8'h06
`define SFRS_OP_WR_DIS 8'h04
`define SFRS_ST_BUSY 0
`define SFRS_ST_WEL 1
`define SFRS_ST_BP_LO 2
`define SFRS_ST_BP_HI 3
`define SFRS_ST_LOCK 7
`define SFRS_ST_WMASK 8'h8C
`define SFRS_NV_RESET 3'h0
`define SFRS_ADDR_TOP 18'h3FFFF
`define SFRS_STWR_TIME_US 10
`endif

// ---- verification/sfrs_chk_asserts.sv ----
// port checker for the serial flash command block
`timescale 1ns/1ps
`default_nettype none
module sfrs_chk #(parameter AW = 18) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic so_o,
  input wire logic so_oe,
  input wire logic [7:0] mem_addr,
  input wire logic [AW-1:0] mem_addr_full,
  input wire logic [2:0] nv_data,
  input wire logic nv_write
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // link pins pass a sync chain, so each step is judged only once it settled
  sequence s_off; cs_n [*6]; endsequence
  sequence s_on; !cs_n [*6] ##0 so_oe; endsequence
  sequence s_hi; sck [*4]; endsequence
  a_oe_off: assert property (s_off |-> !so_oe) else $error("driven deselected");
  a_oe_sel: assert property ($rose(so_oe) |-> !cs_n) else $error("driven unselected");
  a_oe_holds: assert property (s_on |=> so_oe) else $error("stream cut");
  a_so_steady: assert property (s_hi |-> $stable(so_o)) else $error("out moved");
  a_nv_pulse: assert property (nv_write |=> !nv_write) else $error("long pulse");
  a_nv_commit: assert property ($changed(nv_data) |-> nv_write || $past(nv_write))
    else $error("nv moved");
  a_addr_low: assert property (mem_addr == mem_addr_full[7:0]) else $error("low byte");
  a_addr_step: assert property ($past(so_oe) && so_oe && $changed(mem_addr_full)
    |-> mem_addr_full == $past(mem_addr_full) + 1'b1) else $error("addr step");
endmodule
bind sfrs_core sfrs_chk #(.AW(AW)) chk_u (.ref_clk(ref_clk), .rst(rst), .sck(sck),
  .cs_n(cs_n), .so_o(so_o), .so_oe(so_oe), .mem_addr(mem_addr),
  .mem_addr_full(mem_addr_full), .nv_data(nv_data), .nv_write(nv_write));
`default_nettype wire

// ---- verification/sfrs_host.sv ----
// host model driving the serial link in mode 0
`timescale 1ns/1ps
`default_nettype none
module sfrs_host (
  input wire logic ref_clk,
  input wire logic so_o,
  input wire logic so_oe,
  output logic sck,
  output logic cs_n,
  output logic si
);
  // idle: select high, clock parked low
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // four system clocks a half bit, 320 ns per bit
  task automatic half();
    repeat (4) @(posedge ref_clk);
    #1;
  endtask
  task automatic sel();
    cs_n = 1'b0;
    half();
  endtask
  // select rises right after the last bit, data line then toggles
  task automatic desel();
    half();
    cs_n = 1'b1;
    si = ~si;
    half();
    half();
  endtask
  // a released output reads as the inverse of its last level
  task automatic xb(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      si = tx[i];
      half();
      sck = 1'b1;
      half();
      rx[i] = so_oe ? so_o : ~so_o;
      sck = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ---- verification/sfrs_core_tb.sv ----
// self-checking bench for the serial flash command block
`timescale 1ns/1ps
`default_nettype none
module sfrs_core_tb;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic wp_n = 1'b1;
  logic [7:0] rx;
  wire sck, cs_n, si, so_o, so_oe, nv_write;
  wire [7:0] mem_data;
  wire [17:0] mem_addr_full;
  wire [2:0] nv_data;
  integer errors = 0;
  integer samples_checked = 0;
  integer cycles = 0;
  integer seed = 32'h4FBF;
  integer nv = 0;
  integer wel = 0;
  integer nv_pulses = 0;
  integer commits = 0;
  logic [7:0] exp_q[$];
  function automatic logic [7:0] img(input logic [17:0] a);
    img = a[7:0] ^ {a[17:16], 6'h15};
  endfunction
  // array image seen by the block
  assign mem_data = img(mem_addr_full);
  sfrs_core #(.STWR_CYCLES(400)) dut_u (.ref_clk(ref_clk), .rst(rst), .sck(sck),
    .cs_n(cs_n), .si(si), .wp_n(wp_n), .so_o(so_o), .so_oe(so_oe), .mem_addr(),
    .mem_addr_full(mem_addr_full), .mem_data(mem_data), .nv_data(nv_data),
    .nv_write(nv_write));
  sfrs_host host_u (.ref_clk(ref_clk), .so_o(so_o), .so_oe(so_oe), .sck(sck),
    .cs_n(cs_n), .si(si));
  always #20 ref_clk = ~ref_clk;
  // hang guard well above the planned traffic; also counts commit pulses
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (nv_write === 1'b1) begin
      nv_pulses <= nv_pulses + 1;
    end
    if (cycles == 60000) begin
      errors = errors + 1;
      $display("mismatch %0t timeout", $time);
      give_verdict();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("mismatch %0t got %h want %h", $time, got, exp);
    end
  endtask
  // two bytes per frame show the repeat
  task automatic stat(input logic [7:0] e);
    host_u.sel();
    host_u.xb(8'h05, rx);
    host_u.xb(8'h00, rx);
    chk(rx, e);
    host_u.xb(8'h00, rx);
    chk(rx, e);
    host_u.desel();
  endtask
  task automatic wr(input logic pin, input logic en, input logic extra, input logic [7:0] d);
    logic ok;
    wp_n = pin;
    if (en) begin
      host_u.sel();
      host_u.xb(8'h06, rx);
      host_u.desel();
      wel = 1;
    end
    ok = wel && !(nv[7] && !pin) && !extra;
    host_u.sel();
    host_u.xb(8'h01, rx);
    host_u.xb(d, rx);
    if (extra) host_u.xb(d, rx);
    host_u.desel();
    if (ok) begin
      stat(nv | 8'h03);
      repeat (400) @(posedge ref_clk);
      #1;
      nv = d & 8'h8C;
      wel = 0;
      commits = commits + 1;
    end
    stat(nv | wel * 2);
    chk({5'h00, nv_data}, {5'h00, nv[7], nv[3:2]});
    // one commit pulse per accepted write, none for a refused one
    chk(nv_pulses[7:0], commits[7:0]);
  endtask
  task automatic rd(input logic [7:0] op, input logic [23:0] a, input integer n);
    host_u.sel();
    host_u.xb(op, rx);
    host_u.xb(a[23:16], rx);
    host_u.xb(a[15:8], rx);
    host_u.xb(a[7:0], rx);
    if (op == 8'h0B) host_u.xb(8'h00, rx);
    // expected stream in order; the 18-bit argument carries the wrap
    for (int j = 0; j < n; j++) begin
      exp_q.push_back(img(a[17:0] + j));
    end
    for (int i = 0; i < n; i++) begin
      host_u.xb(8'h00, rx);
      chk(rx, exp_q.pop_front());
    end
    host_u.desel();
    chk({7'h00, so_oe}, 8'h00);
  endtask
  task automatic give_verdict();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
    stat(8'h00);
    wr(1'b1, 1'b0, 1'b0, 8'hFF);
    wr(1'b1, 1'b1, 1'b1, 8'hFF);
    wr(1'b1, 1'b0, 1'b0, $random(seed) | 8'h80);
    wr(1'b0, 1'b1, 1'b0, $random(seed));
    wr(1'b1, 1'b0, 1'b0, $random(seed) & 8'h7F);
    rd(8'h03, $random(seed), 3);
    rd(8'h0B, $random(seed) | 24'h03FFFE, 4);
    // write latch set, then cleared again by the disable command
    host_u.sel();
    host_u.xb(8'h06, rx);
    host_u.desel();
    stat(nv | 8'h02);
    host_u.sel();
    host_u.xb(8'h04, rx);
    host_u.desel();
    stat(nv);
    give_verdict();
  end
endmodule
`default_nettype wire
